// file: cdls_pkg.sv
// Package for the core drive line select block
package cdls_pkg;

    // ==========================================
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ADDR = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_XSEL = 8'h10;
    localparam logic [7:0] ADDR_YSEL = 8'h14;

    // ==========================================
    // Control register fields
    localparam int CTRL_READ_CALL = 0;
    localparam int CTRL_WRITE_CALL = 1;
    localparam int CTRL_MAIN_SEL = 2;

    // ==========================================
    // Address bit positions (bit 15 is MSB of the 15-bit field)
    localparam int ADDR_W = 15;
    localparam int DATA_W = 18;
    localparam int B15 = 14;
    localparam int B16 = 13;
    localparam int B17 = 12;
    localparam int B18 = 11;
    localparam int B19 = 10;
    localparam int B20 = 9;
    localparam int B21 = 8;
    localparam int B22 = 7;
    localparam int B23 = 6;
    localparam int B24 = 5;
    localparam int B25 = 4;
    localparam int B26 = 3;
    localparam int B27 = 2;
    localparam int B28 = 1;
    localparam int B29 = 0;

    // ==========================================
    // Storage clock timing, 25 ns taps rounded up to 3 clocks (30 ns) at 100 MHz
    localparam int TAP_NS = 25;
    localparam int CLK_NS = 10;
    localparam int TAP_CYC = (TAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYCLE_TAPS = 20;
    localparam int PW_TAPS = 4;
    localparam logic [4:0] T_RD1_ON = 5'd2;
    localparam logic [4:0] T_RD2_ON = 5'd3;
    localparam logic [4:0] T_SRC_ON = 5'd4;
    localparam logic [4:0] T_SRC_OFF = 5'd12;
    localparam logic [4:0] T_INH_ON = 5'd3;
    localparam logic [4:0] T_END = 5'd19;

    // ==========================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } cdls_state_t;

    typedef struct packed {
        logic rd_set;
        logic wr_set;
        logic pulse_width;
        logic rd1;
        logic rd2;
        logic wr_lat;
        logic x_src;
        logic y_src;
        logic inhibit;
    } cdls_timing_t;

    typedef struct packed {
        logic [1:0] x_rd_ctrl;
        logic [1:0] x_wr_ctrl;
        logic y_rd_ctrl;
        logic y_wr_ctrl;
        logic x_rd_src;
        logic x_wr_src;
        logic y_rd_src;
        logic y_wr_src;
        logic [7:0] x_src_dec;
        logic [7:0] x_snk_dec;
        logic [15:0] y_src_dec;
        logic [15:0] y_snk_dec;
        logic [DATA_W-1:0] inhibit;
    } cdls_drive_t;

endpackage : cdls_pkg

// file: cdls_decode.sv
// Address decode shared by read and write drive paths
`timescale 1ns/100ps
module cdls_decode
    import cdls_pkg::*;
(
    input wire logic [cdls_pkg::ADDR_W-1:0] addr,
    output logic [7:0] x_a,
    output logic [7:0] x_b,
    output logic [15:0] y_a,
    output logic [15:0] y_b
);
    // ==========================================
    // One-hot decode of a three-bit group
    function automatic logic [7:0] dec3(input logic [2:0] v);
        dec3 = 8'h01 << v;
    endfunction : dec3

    always_comb
    begin
        x_a = dec3({addr[B24], addr[B25], addr[B26]});
        x_b = dec3({addr[B27], addr[B28], addr[B29]});
        // Y uses bits 17 to 23 only
        y_a = 16'h0000;
        y_b = 16'h0000;
        if (addr[B18])
        begin
            y_a[15:8] = dec3({addr[B17], addr[B19], addr[B20]});
            y_b[15:8] = dec3({addr[B21], addr[B22], addr[B23]});
        end
        else
        begin
            y_a[7:0] = dec3({addr[B17], addr[B19], addr[B20]});
            y_b[7:0] = dec3({addr[B21], addr[B22], addr[B23]});
        end
    end
endmodule : cdls_decode

// file: cdls_core.sv
// Core drive line select top with APB register access
// Functional notes
// - Y read source pulses in read cycle only when unit selected
// - Write drives same lines as read, opposite direction
// - Eight X decode drivers each end, read and write parts
// - X decode ANDs bits 24-26 one end, 27-29 other end
// - Bit 16 picks X read control section during read 1 timing
// - Bit 16 picks X write control section during write latch
// - One driver per side enables exactly one X line
// - Read and write share one address decode
// - Sixteen Y drivers per end from bits 17-20 and 18,21-23
// - Bit 18 chooses Y driver group at each end
// - Driver active only when pattern ones on, zeros off
// - Y drivers ignore bits 16 and 24-29; bit 15 on disables them
// - Read call with pulse width idle starts clock, sets read set
// - Main select routes to main storage, else extension
// - Y read controls need main select and read 2 timing
// - Y read source needs source timing and bit 15 off
// - Y source switch needs source, read 2 control, bits
// - Y sink switch needs read 2 control, sink, bits
// - Write call sets write set only when bit 15 off
// - Store line one blocks inhibit, zero drives inhibit
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module cdls_core
    import cdls_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output cdls_pkg::cdls_drive_t drive,
    output logic main_storage,
    output logic ext_storage
);
    import cdls_pkg::*;

    // ==========================================
    // State
    typedef struct packed {
        cdls_state_t st;
        cdls_timing_t tm;
        logic [4:0] tap;
        logic [1:0] sub;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic main_sel;
        logic pend_rd;
        logic pend_wr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        cdls_drive_t drv;
        logic main_o;
        logic ext_o;
    } cdls_core_state_t;

    cdls_core_state_t r;
    cdls_core_state_t next_r;
    logic [7:0] x_a;
    logic [7:0] x_b;
    logic [15:0] y_a;
    logic [15:0] y_b;
    logic go;
    logic acc;
    logic set_rd;
    logic set_wr;

    cdls_decode u_dec
    (
        .addr(r.addr),
        .x_a(x_a),
        .x_b(x_b),
        .y_a(y_a),
        .y_b(y_b)
    );

    assign go = ~r.addr[B15];
    assign acc = psel & penable;
    // Calls arriving while a pending one is served stay pending
    assign set_rd = acc && !r.pready && pwrite && (paddr == ADDR_CTRL)
        && pwdata[CTRL_READ_CALL];
    assign set_wr = acc && !r.pready && pwrite && (paddr == ADDR_CTRL)
        && pwdata[CTRL_WRITE_CALL];

    // ==========================================
    // Next state
    always_comb
    begin
        next_r = r;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        // APB access, one wait state
        if (acc && !r.pready)
        begin
            next_r.pready = 1'b1;
            if (pwrite)
            begin
                case (paddr)
                    ADDR_CTRL:
                    begin
                        next_r.pend_rd = r.pend_rd | pwdata[CTRL_READ_CALL];
                        next_r.pend_wr = r.pend_wr | pwdata[CTRL_WRITE_CALL];
                        next_r.main_sel = pwdata[CTRL_MAIN_SEL];
                    end
                    ADDR_ADDR: next_r.addr = pwdata[ADDR_W-1:0];
                    ADDR_DATA: next_r.data = pwdata[DATA_W-1:0];
                    ADDR_STAT, ADDR_XSEL, ADDR_YSEL: next_r.pslverr = 1'b0;
                    default: next_r.pslverr = 1'b1;
                endcase
            end
            else
            begin
                case (paddr)
                    ADDR_CTRL: next_r.prdata = {29'h0, r.main_sel,
                        r.pend_wr, r.pend_rd};
                    ADDR_ADDR: next_r.prdata = {17'h0, r.addr};
                    ADDR_DATA: next_r.prdata = {14'h0, r.data};
                    ADDR_STAT: next_r.prdata = {20'h0, r.tap,
                        r.st != ST_IDLE, r.tm.rd_set, r.tm.wr_set,
                        r.tm.pulse_width, r.tm.inhibit, r.tm.x_src,
                        r.tm.y_src};
                    ADDR_XSEL: next_r.prdata = {16'h0, r.drv.x_snk_dec,
                        r.drv.x_src_dec};
                    ADDR_YSEL: next_r.prdata = {r.drv.y_snk_dec,
                        r.drv.y_src_dec};
                    default:
                    begin
                        next_r.prdata = 32'h0000_0000;
                        next_r.pslverr = 1'b1;
                    end
                endcase
            end
        end

        // Storage clock taps
        if (r.st != ST_IDLE)
        begin
            next_r.sub = r.sub + 2'd1;
            if (r.sub == 2'(TAP_CYC - 1))
            begin
                next_r.sub = 2'd0;
                next_r.tap = r.tap + 5'd1;
            end
        end

        case (r.st)
            ST_IDLE:
            begin
                next_r.tm = '0;
                next_r.tap = 5'd0;
                next_r.sub = 2'd0;
                if (r.pend_rd && !r.tm.pulse_width)
                begin
                    next_r.pend_rd = set_rd;
                    next_r.st = ST_READ;
                    next_r.tm.rd_set = 1'b1;
                    next_r.tm.pulse_width = 1'b1;
                end
                else if (r.pend_wr && !r.tm.pulse_width)
                begin
                    next_r.pend_wr = set_wr;
                    next_r.st = ST_WRITE;
                    next_r.tm.pulse_width = 1'b1;
                    // Write set gated by unit enable
                    next_r.tm.wr_set = go;
                end
            end
            ST_READ, ST_WRITE:
            begin
                next_r.tm.pulse_width = (r.tap < 5'(PW_TAPS));
                next_r.tm.rd1 = r.tm.rd_set && r.tap >= T_RD1_ON
                    && r.tap < T_SRC_OFF;
                next_r.tm.rd2 = r.tm.rd_set && r.tap >= T_RD2_ON
                    && r.tap < T_SRC_OFF;
                next_r.tm.wr_lat = r.tm.wr_set && r.tap >= T_RD1_ON
                    && r.tap < T_SRC_OFF;
                next_r.tm.x_src = r.tap >= T_SRC_ON && r.tap < T_SRC_OFF;
                next_r.tm.y_src = r.tap >= T_SRC_ON && r.tap < T_SRC_OFF;
                next_r.tm.inhibit = r.tm.wr_set && r.tap >= T_INH_ON
                    && r.tap < T_SRC_OFF;
                if (r.tap == T_END && r.sub == 2'(TAP_CYC - 1))
                begin
                    next_r.st = ST_IDLE;
                    next_r.tm = '0;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase

        // ==========================================
        // Drive outputs
        // Main or extension routing
        next_r.main_o = r.main_sel;
        next_r.ext_o = ~r.main_sel;
        // X read control by bit 16
        next_r.drv.x_rd_ctrl = r.tm.rd1 ?
            (r.addr[B16] ? 2'b10 : 2'b01) : 2'b00;
        // X write control by bit 16 and write latch
        next_r.drv.x_wr_ctrl = r.tm.wr_lat ?
            (r.addr[B16] ? 2'b10 : 2'b01) : 2'b00;
        // Y read control needs main and read 2
        next_r.drv.y_rd_ctrl = r.main_sel & r.tm.rd2;
        next_r.drv.y_wr_ctrl = r.main_sel & r.tm.wr_lat;
        // Y read source gated by unit enable
        next_r.drv.y_rd_src = r.tm.y_src & r.tm.rd_set & go;
        // Write sources gated the same way, on their own y_wr_src and x_wr_src outputs
        next_r.drv.y_wr_src = r.tm.y_src & r.tm.wr_set & go;
        next_r.drv.x_rd_src = r.tm.x_src & r.tm.rd_set & go;
        next_r.drv.x_wr_src = r.tm.x_src & r.tm.wr_set & go;
        if ((r.tm.rd1 | r.tm.wr_lat) && r.tm.x_src && go)
        begin
            next_r.drv.x_src_dec = x_b;
            next_r.drv.x_snk_dec = x_a;
        end
        else
        begin
            next_r.drv.x_src_dec = 8'h00;
            next_r.drv.x_snk_dec = 8'h00;
        end
        if (r.main_sel && r.tm.y_src && go
            && (r.tm.rd2 | r.tm.wr_lat))
        begin
            next_r.drv.y_src_dec = y_b;
            next_r.drv.y_snk_dec = y_a;
        end
        else
        begin
            next_r.drv.y_src_dec = 16'h0000;
            next_r.drv.y_snk_dec = 16'h0000;
        end
        // Inhibit for zero bits during inhibit timing
        next_r.drv.inhibit = (r.tm.inhibit && go) ? ~r.data
            : {DATA_W{1'b0}};
    end

    // ==========================================
    // Registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.st <= ST_IDLE;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign drive = r.drv;
    assign main_storage = r.main_o;
    assign ext_storage = r.ext_o;

    // ==========================================
    // Assertions
    property p_no_overlap;
        @(posedge pclk) disable iff (!presetn)
        !(r.tm.rd_set && r.tm.wr_set);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("read and write set both active");

    property p_yrd_src;
        @(posedge pclk) disable iff (!presetn)
        drive.y_rd_src |-> !$past(r.addr[B15]) && $past(r.tm.y_src);
    endproperty
    a_yrd_src: assert property (p_yrd_src)
        else $error("y read source without enable");

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_IDLE && r.pend_rd && !r.tm.pulse_width)
            |=> r.tm.rd_set && r.st == ST_READ;
    endproperty
    a_start: assert property (p_start)
        else $error("read call did not start clock");

    property p_wrset;
        @(posedge pclk) disable iff (!presetn)
        r.tm.wr_set |-> !r.addr[B15];
    endproperty
    a_wrset: assert property (p_wrset)
        else $error("write set without unit enable");

    property p_x_onehot;
        @(posedge pclk) disable iff (!presetn)
        drive.x_src_dec != 8'h00 |->
            $onehot(drive.x_src_dec) && $onehot(drive.x_snk_dec);
    endproperty
    a_x_onehot: assert property (p_x_onehot)
        else $error("x decode not one-hot");

    property p_y_onehot;
        @(posedge pclk) disable iff (!presetn)
        drive.y_src_dec != 16'h0000 |->
            $onehot(drive.y_src_dec) && $onehot(drive.y_snk_dec);
    endproperty
    a_y_onehot: assert property (p_y_onehot)
        else $error("y decode not one-hot");

    property p_yctrl;
        @(posedge pclk) disable iff (!presetn)
        drive.y_rd_ctrl |-> $past(r.main_sel) && $past(r.tm.rd2);
    endproperty
    a_yctrl: assert property (p_yctrl)
        else $error("y read control without main or read 2");

    property p_xsec;
        @(posedge pclk) disable iff (!presetn)
        drive.x_rd_ctrl != 2'b00 |->
            drive.x_rd_ctrl == ($past(r.addr[B16]) ? 2'b10 : 2'b01);
    endproperty
    a_xsec: assert property (p_xsec)
        else $error("x read section mismatch");

    property p_inh;
        @(posedge pclk) disable iff (!presetn)
        $past(r.tm.inhibit && !r.addr[B15])
            |-> drive.inhibit == ~$past(r.data);
    endproperty
    a_inh: assert property (p_inh)
        else $error("inhibit pattern wrong");

    property p_xwsec;
        @(posedge pclk) disable iff (!presetn)
        drive.x_wr_ctrl != 2'b00 |->
            $past(r.tm.wr_lat) && drive.x_wr_ctrl ==
            ($past(r.addr[B16]) ? 2'b10 : 2'b01);
    endproperty
    a_xwsec: assert property (p_xwsec)
        else $error("x write section mismatch");

    property p_ext;
        @(posedge pclk) disable iff (!presetn)
        !$past(r.main_sel) |-> drive.y_src_dec == 16'h0000;
    endproperty
    a_ext: assert property (p_ext)
        else $error("y switch on without main storage");

endmodule : cdls_core

// file: cdls_proc_model.sv
// Processor side model: register bus master and storage calls
`timescale 1ns/100ps
module cdls_proc_model
    import cdls_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rd_q;
    logic err_q;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        rd_q = 32'h0000_0000;
        err_q = 1'b0;
    end

    // ==========================================
    // Bus transfer
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // ==========================================
    // Storage calls
    // Call before address
    task automatic read_call(input logic main_sel, input logic [14:0] a);
        xfer(1'b1, ADDR_CTRL, {29'h0000_0000, main_sel, 2'b01});
        xfer(1'b1, ADDR_ADDR, {17'h0_0000, a});
    endtask : read_call

    task automatic write_call(input logic main_sel);
        xfer(1'b1, ADDR_CTRL, {29'h0000_0000, main_sel, 2'b10});
    endtask : write_call
endmodule : cdls_proc_model

// file: core_drive_line_select_tb_top.sv
// Testbench for the core drive line select block
`timescale 1ns/100ps
module core_drive_line_select_tb_top;
    import cdls_pkg::*;
    typedef struct packed {
        logic [14:0] a;
        logic [17:0] d;
        logic [1:0] xc;
    } cdls_row_t;
    localparam cdls_row_t ROWS [5] = '{
        '{15'h0ABC, 18'h2_5A5A, 2'b01}, '{15'h2A83, 18'h2_5A5A, 2'b10},
        '{15'h157C, 18'h1_0F0F, 2'b01}, '{15'h3FFF, 18'h0_0000, 2'b10},
        '{15'h0000, 18'h3_FFFF, 2'b01}};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, main_storage, ext_storage;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    cdls_drive_t drive;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int cnt [6] = '{0, 0, 0, 0, 0, 0};
    int s [6];
    logic [47:0] rd_dec [5];

    always #5 pclk = ~pclk;

    cdls_proc_model pm(.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    cdls_core uut(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive(drive),
        .main_storage(main_storage), .ext_storage(ext_storage));

    // ==========================================
    // Activity counters and timeout
    always @(posedge pclk)
    begin
        cnt[0] += (drive.y_rd_src === 1'b1);
        cnt[1] += (drive.y_wr_src === 1'b1);
        cnt[2] += (drive.x_rd_src === 1'b1);
        cnt[3] += (drive.x_wr_src === 1'b1);
        cnt[4] += (drive.y_rd_ctrl === 1'b1);
        cnt[5] += (drive.y_rd_src === 1'b1 && drive.y_wr_src === 1'b1);
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    // ==========================================
    // Helpers
    task automatic check(input logic [79:0] seen, input logic [79:0] exp,
                         input string m);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : check

    task automatic wait_src(input bit wr);
        int n;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while ((wr ? drive.y_wr_src : drive.y_rd_src) !== 1'b1 && n < 300);
        check(n < 300, 1'b1, "source never on");
    endtask : wait_src

    task automatic wait_idle();
        int n;
        logic pend;
        n = 0;
        do
        begin
            pm.xfer(1'b0, ADDR_CTRL, 32'h0000_0000);
            pend = |pm.rd_q[1:0];
            pm.xfer(1'b0, ADDR_STAT, 32'h0000_0000);
            n++;
        end
        while ((pend !== 1'b0 || pm.rd_q[6] !== 1'b0) && n < 60);
        check(n < 60, 1'b1, "busy stuck");
    endtask : wait_idle

    function automatic logic [47:0] dec();
        return {drive.x_src_dec, drive.x_snk_dec, drive.y_src_dec,
                drive.y_snk_dec};
    endfunction : dec

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            s = cnt;
            pm.xfer(1'b1, ADDR_DATA, {14'h0000, ROWS[i].d});
            pm.read_call(1'b1, ROWS[i].a);
            wait_src(1'b0);
            rd_dec[i] = dec();
            check(drive.x_rd_ctrl, ROWS[i].xc, "x read ctrl");
            check(drive.y_rd_ctrl, 1'b1, "y read ctrl");
            check(main_storage, 1'b1, "main select");
            check({$onehot(drive.x_src_dec), $onehot(drive.x_snk_dec),
                $onehot(drive.y_src_dec), $onehot(drive.y_snk_dec)},
            4'hF, "one line");
            check(drive.x_rd_src, 1'b1, "x read source");
            check(cnt[1] - s[1], 0, "write src in read");
            pm.write_call(1'b1);
            wait_src(1'b1);
            check(dec(), rd_dec[i], "write lines");
            check(drive.x_wr_ctrl, ROWS[i].xc, "x write ctrl");
            check(drive.y_wr_ctrl, 1'b1, "y write ctrl");
            check(drive.x_wr_src, 1'b1, "x write source");
            check(drive.inhibit, 18'(~ROWS[i].d), "inhibit");
            check(drive.y_rd_src, 1'b0, "overlap");
            wait_idle();
        end
        check(rd_dec[1][31:0], rd_dec[0][31:0], "y ignores");
        check(rd_dec[2][47:32], rd_dec[0][47:32], "x ignores");
        check({rd_dec[1][47:40] != rd_dec[0][47:40],
            rd_dec[1][39:32] != rd_dec[0][39:32]}, 2'b11,
            "x ends");
        check({rd_dec[2][31:16] != rd_dec[0][31:16],
            rd_dec[2][15:0] != rd_dec[0][15:0]}, 2'b11,
            "y ends");
        check(cnt[5], 0, "read write overlap");
        $display("table rows done");
        s = cnt;
        pm.read_call(1'b1, 15'h4ABC);
        pm.write_call(1'b1);
        wait_idle();
        for (int k = 0; k < 4; k++)
            check(cnt[k] - s[k], 0, "unit not selected");
        $display("unit select test done");
        s = cnt;
        pm.read_call(1'b0, 15'h0ABC);
        @(negedge pclk);
        check({main_storage, ext_storage}, 2'b01, "extension");
        wait_idle();
        check(cnt[4] - s[4], 0, "y ctrl no main");
        $display("extension test done");
        pm.xfer(1'b0, 8'h20, 32'h0000_0000);
        check({pm.err_q, pm.rd_q}, 33'h1_0000_0000, "unmapped read");
        pm.xfer(1'b1, 8'h18, 32'hFFFF_FFFF);
        check(pm.err_q, 1'b1, "unmapped write");
        pm.xfer(1'b0, ADDR_CTRL, 32'h0000_0000);
        check({pm.err_q, pm.rd_q}, 33'h0_0000_0000, "ctrl readback");
        $display("register test done");
        pm.read_call(1'b1, 15'h0ABC);
        repeat (10) @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        check({drive, main_storage, ext_storage}, 80'h0, "in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        check(ext_storage, 1'b1, "after reset");
        pm.xfer(1'b0, ADDR_STAT, 32'h0000_0000);
        check(pm.rd_q, 32'h0000_0000, "status reset");
        $display("reset test done");
        stop_test();
    end
endmodule : core_drive_line_select_tb_top
